// ### hdl/rirc_ctrl.sv
// reset generation and interrupt request control
// Behaviour
// - four reset sources, three are malfunction
// - malfunction reset held 24 clocks, pin low
// - power-up malfunction pulse may appear
// - external reset needs twelve clocks low; here any sampled low starts a reset of at least twelve clocks
// - after reset fetch vector at top
// - reset clears prescaler, watchdog left enabled
// - reset clears master, enables, latches
// - trap on fetch into protected areas
// - bad oscillator enable write gives reset
// - eighteen sources, two shared levels, four nonmaskable
// - request sets latch, latch asks acceptance
// - fixed priority, nesting, nonmaskables first
// - reset, software, trap, watchdog vectors
// - maskable levels descend from FFF6
// - maskable needs master and own enable
// - levels 14, 15 select their source
// - trap defaults to reset request
// - watchdog defaults to reset request
// - acceptance clears pending latch
// - acceptance stacks and clears master enable
`default_nettype none
module rirc_ctrl
  import rirc_pkg::*;
#(
  parameter int unsigned MAL_CYC = MAL_RST_CYC,
  parameter int unsigned EXT_CYC = EXT_RST_MIN_CYC,
  parameter logic [15:0] SPF_LO = 16'h0000,
  parameter logic [15:0] SPF_HI = 16'h003F,
  parameter logic [15:0] RAM_LO = 16'h0040,
  parameter logic [15:0] RAM_HI = 16'h083F,
  parameter logic [15:0] BUF_LO = 16'h0F80,
  parameter logic [15:0] BUF_HI = 16'h0FFF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  output logic core_rst_n_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic fetch_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic wdt_event_i,
  input wire logic [15:4] src_req_i,
  input wire logic serial_transmit_source_i,
  input wire logic converter_done_source_i,
  input wire logic software_trap_source_i,
  input wire logic undefined_opcode_source_i,
  output logic irq_o,
  output logic [15:0] irq_vector_o,
  input wire logic irq_ack_i,
  input wire logic reti_i,
  input wire logic reti_mie_i,
  output logic stacked_mie_o,
  output logic [7:0] tgen_count_o
);
  logic master_irq_enable_r;
  logic [15:4] source_irq_enable_r;
  logic [15:2] pending_request_latch_r;
  logic [6:0] ctrl_r;
  logic [2:0] sysc_r;
  logic [2:0] sysc_nxt;
  logic stacked_mie_r;
  logic [7:0] tgen_r;
  rirc_rst_state_t state_r;
  logic [4:0] cnt_r;
  logic [2:0] cause_r;
  logic [15:0] rdata_r;
  logic pin_s;

  // the pin is sampled through two flops before the counter looks at it
  rirc_sync2 #(.INIT(1'b0)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(reset_pin_i),
    .q_o(pin_s)
  );

  wire logic ram_trap_select = ctrl_r[CTL_RAMTRAP];
  wire logic trap_output_select = ctrl_r[CTL_TRAPOUT];
  wire logic watchdog_output_select = ctrl_r[CTL_WDOGSEL];
  wire logic level14_source_select = ctrl_r[CTL_SEL14];
  wire logic level15_source_select = ctrl_r[CTL_SEL15];
  wire logic ext_input0_pin_enable = ctrl_r[CTL_PINEN];

  wire logic wr_eir = reg_wr_i && reg_addr_i == ADR_EIR;
  wire logic wr_pend = reg_wr_i && reg_addr_i == ADR_PEND;
  wire logic wr_ctl = reg_wr_i && reg_addr_i == ADR_CTRL;
  wire logic wr_sys = reg_wr_i && reg_addr_i == ADR_SYSC;

  // fetch into the special-function area, buffer region or guarded ram
  wire logic in_spf = fetch_addr_i >= SPF_LO && fetch_addr_i <= SPF_HI;
  wire logic in_buf = fetch_addr_i >= BUF_LO && fetch_addr_i <= BUF_HI;
  wire logic in_ram = fetch_addr_i >= RAM_LO && fetch_addr_i <= RAM_HI;
  wire logic trap_hit = fetch_i && (in_spf || in_buf || (in_ram && ram_trap_select));

  // oscillator enable writes that would leave the selected clock dead
  always_comb begin
    sysc_nxt = reg_wdata_i[2:0];
  end
  wire logic both_off = sysc_r[SYS_XEN] && sysc_r[SYS_XTEN]
      && !sysc_nxt[SYS_XEN] && !sysc_nxt[SYS_XTEN];
  wire logic hi_off = sysc_r[SYS_XEN] && !sysc_nxt[SYS_XEN] && !sysc_r[SYS_SYSCK];
  wire logic lo_off = sysc_r[SYS_XTEN] && !sysc_nxt[SYS_XTEN] && sysc_r[SYS_SYSCK];
  wire logic clk_fault = wr_sys && (both_off || hi_off || lo_off);

  wire logic trap_rst = trap_hit && trap_output_select;
  wire logic wdt_rst = wdt_event_i && watchdog_output_select;
  wire logic mal_req = trap_rst || wdt_rst || clk_fault;

  // shared levels only latch the selected source
  logic [15:4] lvl_req;
  always_comb begin
    lvl_req = src_req_i;
    lvl_req[14] = level14_source_select ? serial_transmit_source_i : src_req_i[14];
    lvl_req[15] = level15_source_select ? converter_done_source_i : src_req_i[15];
  end

  // both unlatched sources share one level and one vector
  wire logic nmi_soft = software_trap_source_i || undefined_opcode_source_i;

  // acceptance candidates: nonmaskables always, maskables gated
  logic [15:0] cand;
  always_comb begin
    cand = '0;
    cand[1] = nmi_soft;
    cand[LVL_TRAP] = pending_request_latch_r[LVL_TRAP];
    cand[LVL_WDT] = pending_request_latch_r[LVL_WDT];
    for (int i = LVL_FIRST_MASK; i < NUM_LEVELS; i++) begin
      cand[i] = master_irq_enable_r && source_irq_enable_r[i]
          && pending_request_latch_r[i];
    end
    cand[LVL_FIRST_MASK] = cand[LVL_FIRST_MASK] && ext_input0_pin_enable;
  end

  logic any_req;
  logic [3:0] win;
  rirc_prio #(.N(NUM_LEVELS)) u_prio (
    .req_i(cand),
    .any_o(any_req),
    .idx_o(win)
  );

  // level n at or above 4 maps to FFF6 minus twice (n - 4)
  logic [15:0] vec;
  always_comb begin
    case (win)
      4'd1: vec = VEC_SWI;
      4'd2: vec = VEC_TRAP;
      4'd3: vec = VEC_WDT;
      default: vec = VEC_LVL4 - {11'h000, win - 4'd4, 1'b0};
    endcase
  end
  assign irq_o = any_req && state_r == RIRC_RUN;
  assign irq_vector_o = (state_r == RIRC_RUN) ? vec : VEC_RESET;

  wire logic accept = irq_ack_i && irq_o;
  // core held and registers forced while any reset stretch runs
  wire logic in_reset = state_r != RIRC_RUN;

  // counter loads for the two reset stretches
  wire logic [4:0] mal_load = 5'(MAL_CYC - 1);
  wire logic [4:0] ext_load = 5'(EXT_CYC - 1);

  // reset sequencer: malfunction stretch, then wait for the pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= RIRC_EXTRST;
      cnt_r <= '0;
    end else begin
      case (state_r)
        RIRC_RUN: begin
          if (mal_req) begin
            state_r <= RIRC_MALRST;
            cnt_r <= mal_load;
          end else if (!pin_s) begin
            state_r <= RIRC_EXTRST;
            cnt_r <= ext_load;
          end
        end
        RIRC_MALRST: begin
          if (cnt_r == 5'h0_0) begin
            state_r <= RIRC_EXTRST;
          end else begin
            cnt_r <= cnt_r - 5'h0_1;
          end
        end
        RIRC_EXTRST: begin
          if (cnt_r != 5'h0_0) begin
            cnt_r <= cnt_r - 5'h0_1;
          end else if (pin_s) begin
            state_r <= RIRC_RUN;
          end
        end
        default: state_r <= RIRC_EXTRST;
      endcase
    end
  end
  // the core is released only once the synchronised pin is high again
  assign core_rst_n_o = !in_reset;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_o = state_r == RIRC_MALRST;

  // reset cause, read by software afterwards
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_r <= '0;
    end else if (state_r == RIRC_RUN && mal_req) begin
      cause_r <= {clk_fault, wdt_rst, trap_rst};
    end
  end

  // master enable: acceptance clears it, return loads reti_mie_i
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_irq_enable_r <= 1'b0;
    end else if (in_reset) begin
      master_irq_enable_r <= 1'b0;
    end else if (accept) begin
      master_irq_enable_r <= 1'b0;
    end else if (reti_i) begin
      master_irq_enable_r <= reti_mie_i;
    end else if (wr_eir) begin
      master_irq_enable_r <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stacked_mie_r <= 1'b0;
    end else if (accept) begin
      stacked_mie_r <= master_irq_enable_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_irq_enable_r <= SRC_EN_RST[15:4];
    end else if (in_reset) begin
      source_irq_enable_r <= SRC_EN_RST[15:4];
    end else if (wr_eir) begin
      source_irq_enable_r <= reg_wdata_i[15:4];
    end
  end

  // control defaults: trap and watchdog to reset request, watchdog on
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTL_RST;
    end else if (in_reset) begin
      ctrl_r <= CTL_RST;
    end else if (wr_ctl) begin
      ctrl_r <= reg_wdata_i[6:0];
    end
  end

  // a write that would stop the selected clock is not stored
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysc_r <= SYS_RST;
    end else if (in_reset) begin
      sysc_r <= SYS_RST;
    end else if (wr_sys && !clk_fault) begin
      sysc_r <= sysc_nxt;
    end
  end

  assign stacked_mie_o = stacked_mie_r;

  // pending latches: hardware set wins over software clear and acceptance
  logic [15:2] set_v;
  logic [15:2] clr_v;
  always_comb begin
    set_v = '0;
    set_v[15:4] = lvl_req;
    set_v[LVL_TRAP] = trap_hit && !trap_output_select;
    set_v[LVL_WDT] = wdt_event_i && !watchdog_output_select;
    clr_v = '0;
    if (wr_pend) begin
      clr_v = ~reg_wdata_i[15:2];
    end
    if (accept && win >= 4'd2) begin
      clr_v[win] = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_request_latch_r <= PEND_RST[15:2];
    end else if (in_reset) begin
      pending_request_latch_r <= PEND_RST[15:2];
    end else begin
      pending_request_latch_r <= (pending_request_latch_r & ~clr_v) | set_v;
    end
  end

  // timing generator prescaler, zeroed by reset
  wire logic [7:0] tgen_nxt = tgen_r + 8'h01;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgen_r <= '0;
    end else if (in_reset) begin
      tgen_r <= '0;
    end else begin
      tgen_r <= tgen_nxt;
    end
  end
  assign tgen_count_o = tgen_r;

  // read port: data stand one cycle after the strobe, only then
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      ADR_EIR: rd_mux = {source_irq_enable_r, 3'b000, master_irq_enable_r};
      ADR_PEND: rd_mux = {pending_request_latch_r, 2'b00};
      ADR_CTRL: rd_mux = {9'h000, ctrl_r};
      ADR_SYSC: rd_mux = {13'h0000, sysc_r};
      ADR_STAT: rd_mux = {11'h000, win, any_req};
      ADR_TGEN: rd_mux = {8'h00, tgen_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // cause bits overlay the low status bits on a status read
  wire logic rd_stat = reg_addr_i == ADR_STAT;
  wire logic [15:0] cause_ovl = {13'h0000, cause_r & {3{rd_stat}}};
  wire logic [15:0] rd_word = rd_mux | cause_ovl;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd_i ? rd_word : 16'h0000;
    end
  end
  assign reg_rdata_o = rdata_r;
endmodule // rirc_ctrl
`default_nettype wire

// ### hdl/rirc_pkg.sv
// package: constants for the reset and interrupt request controller
`default_nettype none
package rirc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // malfunction reset stretch, in main-clock periods
  localparam int unsigned MAL_RST_CYC = 24;
  // least external reset width, in main-clock periods
  localparam int unsigned EXT_RST_MIN_CYC = 12;
  localparam int unsigned NUM_LEVELS = 16;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SWI = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP = 16'hFFFA;
  localparam logic [15:0] VEC_WDT = 16'hFFF8;
  localparam logic [15:0] VEC_LVL4 = 16'hFFF6;
  localparam int unsigned LVL_TRAP = 2;
  localparam int unsigned LVL_WDT = 3;
  localparam int unsigned LVL_FIRST_MASK = 4;
  localparam logic [15:0] SRC_EN_RST = 16'h0000;
  localparam logic [15:0] PEND_RST = 16'h0000;
  // register offsets on the plain register port
  localparam logic [3:0] ADR_EIR = 4'h0;
  localparam logic [3:0] ADR_PEND = 4'h1;
  localparam logic [3:0] ADR_CTRL = 4'h2;
  localparam logic [3:0] ADR_SYSC = 4'h3;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_TGEN = 4'h5;
  // control field positions in ADR_CTRL
  localparam int unsigned CTL_RAMTRAP = 0;
  localparam int unsigned CTL_TRAPOUT = 1;
  localparam int unsigned CTL_WDOGSEL = 2;
  localparam int unsigned CTL_WDTEN = 3;
  localparam int unsigned CTL_SEL14 = 4;
  localparam int unsigned CTL_SEL15 = 5;
  localparam int unsigned CTL_PINEN = 6;
  localparam logic [6:0] CTL_RST = 7'h0_00E;
  // system control three fields: high osc enable, low osc enable, clock select
  localparam int unsigned SYS_XEN = 0;
  localparam int unsigned SYS_XTEN = 1;
  localparam int unsigned SYS_SYSCK = 2;
  localparam logic [2:0] SYS_RST = 3'h1;
  typedef enum logic [1:0] {
    RIRC_RUN = 2'b00,
    RIRC_MALRST = 2'b01,
    RIRC_EXTRST = 2'b10
  } rirc_rst_state_t;
endpackage
`default_nettype wire

// ### hdl/rirc_prio.sv
// finds the lowest-numbered request level and whether any request stands
`default_nettype none
module rirc_prio #(
  parameter int unsigned N = 16
) (
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [3:0] idx_o
);
  always_comb begin
    any_o = 1'b0;
    idx_o = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = 4'(i);
      end
    end
  end
endmodule // rirc_prio

// ### hdl/rirc_sync2.sv
// two-flop synchroniser for an outside level
`default_nettype none
module rirc_sync2 #(
  parameter logic INIT = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= INIT;
      q_o <= INIT;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // rirc_sync2

// ### sim/rirc_cpu_model.sv
// partner: cpu core that accepts requests after a set delay and records vectors
`default_nettype none
module rirc_cpu_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [1:0] lat_i,
  input wire logic core_rst_n_i,
  input wire logic irq_i,
  input wire logic [15:0] vec_i,
  output logic ack_o,
  output logic [15:0] vec_o,
  output logic [15:0] boot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  logic go;
  assign go = en_i && irq_i && !ack_o;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'b00;
      vec_o <= 16'h0000;
      boot_o <= 16'h0000;
    end else begin
      ack_o <= go && wait_r == lat_i;
      wait_r <= (go && wait_r != lat_i) ? wait_r + 2'b01 : 2'b00;
      if (!core_rst_n_i) boot_o <= vec_i;
      if (go && wait_r == lat_i) vec_o <= vec_i;
    end
  end
endmodule // rirc_cpu_model
`default_nettype wire

// ### sim/rirc_ctrl_asserts.sv
// checker: reset and interrupt relations at the controller ports
`default_nettype none
module rirc_ctrl_chk
  import rirc_pkg::*;
#(
  parameter int unsigned MAL_CYC = MAL_RST_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic core_rst_n_o,
  input wire logic fetch_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic irq_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic irq_ack_i,
  input wire logic stacked_mie_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [7:0] oe_cnt_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) oe_cnt_r <= 8'h00;
    else oe_cnt_r <= reset_pin_oe_o ? oe_cnt_r + 8'h01 : 8'h00;
  end
  sequence acc_mask_s;
    irq_ack_i && irq_o && irq_vector_o <= VEC_LVL4;
  endsequence
  sequence pin_low_s;
    !reset_pin_i [*8] ##1 !reset_pin_i [*4];
  endsequence
  AST_PIN_LOW: assert property (reset_pin_oe_o |-> !reset_pin_o && !core_rst_n_o)
    else $error("pin drive without low level and core reset");
  AST_MAL_LEN: assert property ($fell(reset_pin_oe_o) |-> oe_cnt_r == MAL_CYC)
    else $error("malfunction reset length wrong");
  AST_MAL_MAX: assert property (oe_cnt_r <= MAL_CYC)
    else $error("malfunction reset too long");
  AST_RST_VEC: assert property (!core_rst_n_o |-> !irq_o && irq_vector_o == VEC_RESET)
    else $error("request or vector wrong in reset");
  AST_VEC_SET: assert property (irq_o |-> irq_vector_o >= 16'hFFE0 && irq_vector_o <= VEC_SWI
      && !irq_vector_o[0])
    else $error("vector outside table");
  AST_TRAP: assert property (core_rst_n_o && fetch_i && fetch_addr_i <= 16'h003F
      |-> ##[1:4] (reset_pin_oe_o || irq_o))
    else $error("no trap after protected fetch");
  AST_ACK_STACK: assert property (acc_mask_s |=> stacked_mie_o)
    else $error("master enable not stacked");
  AST_ACK_MASK: assert property (acc_mask_s |=> (!irq_o || irq_vector_o > VEC_LVL4) [*2])
    else $error("maskable request after acceptance");
  AST_ACK_CLR: assert property (irq_ack_i && irq_o && irq_vector_o != VEC_SWI
      |=> !irq_o || irq_vector_o != $past(irq_vector_o))
    else $error("accepted request still pending");
  AST_EXT_RST: assert property (pin_low_s |-> ##[0:8] !core_rst_n_o)
    else $error("long low pin gave no reset");
endmodule // rirc_ctrl_chk
bind rirc_ctrl rirc_ctrl_chk #(.MAL_CYC(MAL_CYC)) rirc_ctrl_chk_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin_i),
  .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .core_rst_n_o(core_rst_n_o),
  .fetch_i(fetch_i), .fetch_addr_i(fetch_addr_i), .irq_o(irq_o),
  .irq_vector_o(irq_vector_o), .irq_ack_i(irq_ack_i), .stacked_mie_o(stacked_mie_o));
`default_nettype wire

// ### sim/tb.sv
// testbench: reset and interrupt controller against a bench model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rirc_pkg::*;
  localparam logic [15:0] FA [4] = '{16'h0100, 16'h0100, 16'h0020, 16'h0F80};
  localparam logic [15:0] CT [4] = '{16'h0008, 16'h0009, 16'h0008, 16'h0008};
  localparam logic [15:0] SW [3][3] = '{'{1, 1, 0}, '{3, 3, 2}, '{3, 7, 5}};
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ext_pin = 1'b1, wr = 1'b0, rd = 1'b0;
  logic fetch = 1'b0, wdt = 1'b0, reti = 1'b0, reti_mie = 1'b0, cpu_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, faddr = 16'hFFFF;
  logic [15:4] src = 12'h000;
  logic [1:0] alt = 2'b00, nm = 2'b00, lat = 2'b00;
  wire logic pin_o, oe, core_n, irq, ack, stk;
  wire logic [15:0] rdata, vec, cvec, boot;
  wire logic [7:0] tgen;
  wire logic pin = oe ? pin_o : ext_pin;
  int errors = 0, num_checks = 0, n, a, b;
  int pend[$];
  always #2 ref_clk_i = ~ref_clk_i;
  rirc_ctrl rirc_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_pin_i(pin),
    .reset_pin_o(pin_o), .reset_pin_oe_o(oe), .core_rst_n_o(core_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fetch_i(fetch),
    .fetch_addr_i(faddr), .wdt_event_i(wdt), .src_req_i(src), .serial_transmit_source_i(alt[0]),
    .converter_done_source_i(alt[1]), .software_trap_source_i(nm[0]),
    .undefined_opcode_source_i(nm[1]), .irq_o(irq), .irq_vector_o(vec), .irq_ack_i(ack),
    .reti_i(reti), .reti_mie_i(reti_mie), .stacked_mie_o(stk), .tgen_count_o(tgen));
  rirc_cpu_model rirc_cpu_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .en_i(cpu_en),
    .lat_i(lat), .core_rst_n_i(core_n), .irq_i(irq), .vec_i(vec), .ack_o(ack), .vec_o(cvec),
    .boot_o(boot));
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wt(input logic core);
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk_i);
      if (core ? core_n === 1'b1 : ack === 1'b1) return;
    end
    chk("wait", 16'h0001, 16'h0000);
    end_of_test();
  endtask
  task automatic wrt(input logic [3:0] ad, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] ad, input logic [15:0] e, input string s);
    @(posedge ref_clk_i);
    addr <= ad;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 chk(s, e, rdata);
  endtask
  task automatic pulse(input logic [15:4] m, input logic w, input logic [1:0] al);
    @(posedge ref_clk_i);
    src <= m;
    wdt <= w;
    alt <= al;
    @(posedge ref_clk_i);
    src <= 12'h000;
    wdt <= 1'b0;
    alt <= 2'b00;
    #1;
  endtask
  task automatic fet(input logic [15:0] fa);
    @(posedge ref_clk_i);
    fetch <= 1'b1;
    faddr <= fa;
    @(posedge ref_clk_i);
    fetch <= 1'b0;
    faddr <= ~fa;
  endtask
  // cpu accepts after a random delay; the level sources drop at the accepting edge
  task automatic go(input logic [15:0] e);
    lat <= 2'($urandom % 4);
    cpu_en <= 1'b1;
    wt(1'b0);
    cpu_en <= 1'b0;
    nm <= 2'b00;
    #1 chk("vector", e, cvec);
  endtask
  function automatic logic [15:0] lv(input int l);
    return VEC_LVL4 - 16'(2 * (l - 4));
  endfunction
  initial begin
    void'($urandom(32'h6819));
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wt(1'b1);
    chk("boot", VEC_RESET, boot);
    rdc(ADR_EIR, SRC_EN_RST, "eir");
    rdc(ADR_PEND, PEND_RST, "pend");
    rdc(ADR_CTRL, 16'(CTL_RST), "ctrl");
    rdc(ADR_SYSC, 16'(SYS_RST), "sysc");
    rdc(4'hF, 16'h0000, "unmapped");
    $display("test reset done");
    for (int l = 5; l < 16; l++) begin
      wrt(ADR_EIR, 16'h0001 | (16'h0001 << l));
      pulse(12'h001 << (l - 4), 1'b0, 2'b00);
      chk("irq", 16'h0001, {15'h0000, irq});
      go(lv(l));
      chk("stacked", 16'h0001, {15'h0000, stk});
      rdc(ADR_PEND, 16'h0000, "pend");
      rdc(ADR_EIR, 16'h0001 << l, "eir");
    end
    @(posedge ref_clk_i);
    reti <= 1'b1;
    reti_mie <= 1'b1;
    @(posedge ref_clk_i);
    reti <= 1'b0;
    rdc(ADR_EIR, 16'h8001, "reti");
    $display("test levels done");
    a = 5 + $urandom % 9;
    b = 5 + (a - 4 + $urandom % 8) % 9;
    pend = {a, b};
    pend.sort();
    wrt(ADR_EIR, 16'h3FE0);
    pulse((12'h001 << (a - 4)) | (12'h001 << (b - 4)), 1'b0, 2'b00);
    chk("masked", 16'h0000, {15'h0000, irq});
    rdc(ADR_PEND, (16'h0001 << a) | (16'h0001 << b), "pend");
    wrt(ADR_EIR, 16'h3FE1);
    go(lv(pend[0]));
    wrt(ADR_PEND, 16'h0000);
    wrt(ADR_EIR, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      nm <= 2'b01 << k;
      go(VEC_SWI);
    end
    wrt(ADR_CTRL, 16'h0008);
    pulse(12'h000, 1'b1, 2'b00);
    rdc(ADR_PEND, 16'h0008, "pend");
    go(VEC_WDT);
    for (int k = 0; k < 4; k++) begin
      wrt(ADR_CTRL, CT[k]);
      fet(FA[k]);
      rdc(ADR_PEND, k > 0 ? 16'h0004 : 16'h0000, "pend trap");
      if (k > 0) go(VEC_TRAP);
    end
    wrt(ADR_CTRL, 16'h0038);
    pulse(12'h000, 1'b0, 2'b11);
    rdc(ADR_PEND, 16'hC000, "pend shared");
    wrt(ADR_PEND, 16'h0000);
    wrt(ADR_EIR, 16'h0011);
    pulse(12'h001, 1'b0, 2'b00);
    chk("irq pin off", 16'h0000, {15'h0000, irq});
    wrt(ADR_CTRL, 16'h0048);
    go(VEC_LVL4);
    $display("test sources done");
    for (int k = 0; k < 5; k++) begin
      wrt(ADR_CTRL, 16'(CTL_RST));
      if (k == 0) fet(16'h0020);
      else if (k == 1) pulse(12'h000, 1'b1, 2'b00);
      else for (int j = 0; j < 3; j++) wrt(ADR_SYSC, SW[k - 2][j]);
      n = 0;
      for (int i = 0; i < 100; i++) begin
        @(posedge ref_clk_i);
        if (oe === 1'b1) n++;
        else if (n > 0) break;
      end
      chk("pin drive", 16'(MAL_RST_CYC), 16'(n));
      wt(1'b1);
      rdc(ADR_CTRL, 16'(CTL_RST), "ctrl");
    end
    rdc(ADR_STAT, 16'h0004, "cause");
    $display("test malfunction done");
    wrt(ADR_EIR, 16'h0011);
    @(posedge ref_clk_i);
    ext_pin <= 1'b0;
    repeat (14) @(posedge ref_clk_i);
    ext_pin <= 1'b1;
    #1 chk("core", 16'h0000, {15'h0000, core_n});
    wt(1'b1);
    #1 chk("tgen", 16'h0001, {8'h00, tgen});
    rdc(ADR_EIR, 16'h0000, "eir");
    $display("test pin reset done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
